// [hdl/pbcaf_override.sv]
`timescale 1ns/1ps
`include "pbcaf_cfg.svh"
// Overview of operation
// - Slave mode forces data-in pin to input
// - Slave mode forces clock pin to input
// - Slave select input in slave, active low
// - Port bit keeps pull-up control when forced
// - Serial pins overrides from enable and mode
// - Serial data and clock routed to pins
// - Change mask and group enable open input
// - Clock pin clocks serial programming
// - Data-in pin carries programming data
// - First-port pins are change sources 0-7
// - Second-port pins are change sources 8-11
// - Second-port pin 7 feeds timer capture
// - Second-port pin 7 feeds external interrupt 4
// - Clock out on pin 7 when fuse allows
// - Compare A output on second-port pin 6
// - Compare B output on second-port pin 5
// - Reset pin: pull-up, no driver, no input
// - Debug fuse with lock bits unprogrammed makes reset pin open-drain line
// - Master mode forces data-out pin to input
// - Pull-up override wins over port bits
// - Direction override sets driver enable
// - Global pull-up disable kills normal pull-ups
module pbcaf_override
	import pbcaf_pkg::*;
#(
	parameter int PORT_WIDTH = 8
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire pbcaf_pkg::pbcaf_apb_req_t     apb_req,
	output pbcaf_pkg::pbcaf_apb_rsp_t          apb_rsp,
	input  wire pbcaf_pkg::pbcaf_periph_in_t   periph_in,
	output pbcaf_pkg::pbcaf_periph_out_t       periph_out,
	input  wire logic [PORT_WIDTH-1:0]         port_b_dir,
	input  wire logic [PORT_WIDTH-1:0]         port_b_out,
	input  wire logic [PORT_WIDTH-1:0]         port_c_dir,
	input  wire logic [PORT_WIDTH-1:0]         port_c_out,
	input  wire logic [PORT_WIDTH-1:0]         pin_b_in,
	input  wire logic [PORT_WIDTH-1:0]         pin_c_in,
	output pbcaf_pkg::pbcaf_pin_ovr_t [PORT_WIDTH-1:0] port_b_ovr,
	output pbcaf_pkg::pbcaf_pin_ovr_t [PORT_WIDTH-1:0] port_c_ovr,
	output pbcaf_pkg::pbcaf_pad_t [PORT_WIDTH-1:0]     pad_b,
	output pbcaf_pkg::pbcaf_pad_t [PORT_WIDTH-1:0]     pad_c
);

	generate
		if (PORT_WIDTH != 8) begin : g_bad_width
			$error("pbcaf_override serves eight-pin ports only");
		end
	endgenerate

	logic [7:0]  ctrl_q;
	logic [7:0]  mask0_q;
	logic [3:0]  mask1_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic [7:0]  sync1_b_q;
	logic [7:0]  sync2_b_q;
	logic [7:0]  sync3_b_q;
	logic [7:0]  pin_b_q;
	logic [7:0]  sync1_c_q;
	logic [7:0]  sync2_c_q;
	logic [7:0]  sync3_c_q;
	logic [7:0]  pin_c_q;
	logic        ss_active_q;

	logic        global_pullup_disable;
	logic        grp0_en;
	logic        grp1_en;
	logic        spi_master;
	logic        spi_slave;
	logic        setup;
	logic        access;
	logic        mapped;
	logic [31:0] rdata_d;

	assign global_pullup_disable        = ctrl_q[`PBCAF_CTRL_PUD_BIT];
	assign grp0_en    = ctrl_q[`PBCAF_CTRL_GRP0_BIT];
	assign grp1_en    = ctrl_q[`PBCAF_CTRL_GRP1_BIT];
	assign spi_master = periph_in.serial_if_enable & periph_in.serial_master_select;
	assign spi_slave  = periph_in.serial_if_enable & ~periph_in.serial_master_select;

	// APB slave: one wait-free access cycle, answer registered
	assign setup  = apb_req.psel & ~apb_req.penable & ~pready_q;
	assign access = apb_req.psel & apb_req.penable & pready_q;

	always_comb begin
		mapped  = 1'b1;
		rdata_d = 32'h0000_0000;
		if (apb_req.paddr == `PBCAF_CTRL_OFS) begin
			rdata_d[7:0] = ctrl_q;
		end else if (apb_req.paddr == `PBCAF_MASK0_OFS) begin
			rdata_d[7:0] = mask0_q;
		end else if (apb_req.paddr == `PBCAF_MASK1_OFS) begin
			rdata_d[3:0] = mask1_q;
		end else if (apb_req.paddr == `PBCAF_STATUS_OFS) begin
			rdata_d[`PBCAF_STAT_PINB_LSB +: 8] = pin_b_q;
			rdata_d[`PBCAF_STAT_PINC_LSB +: 8] = pin_c_q;
			rdata_d[`PBCAF_STAT_SSACT_BIT]     = ss_active_q;
		end else begin
			mapped = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~mapped;
			prdata_q  <= (setup & ~apb_req.pwrite) ? rdata_d : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= `PBCAF_CTRL_RST;
			mask0_q <= `PBCAF_MASK0_RST;
			mask1_q <= `PBCAF_MASK1_RST;
		end else if (access & apb_req.pwrite) begin
			if (apb_req.paddr == `PBCAF_CTRL_OFS) begin
				ctrl_q <= apb_req.pwdata[7:0] & 8'h13;
			end else if (apb_req.paddr == `PBCAF_MASK0_OFS) begin
				mask0_q <= apb_req.pwdata[7:0];
			end else if (apb_req.paddr == `PBCAF_MASK1_OFS) begin
				mask1_q <= apb_req.pwdata[3:0];
			end
		end
	end

	assign apb_rsp.prdata  = prdata_q;
	assign apb_rsp.pready  = pready_q;
	assign apb_rsp.pslverr = pslverr_q;

	// Pin levels for the status view only; peripherals get raw levels and
	// synchronise themselves, so a filtered copy here would add latency there
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_b_q <= 8'h00;
			sync2_b_q <= 8'h00;
			sync3_b_q <= 8'h00;
			pin_b_q   <= 8'h00;
			sync1_c_q <= 8'h00;
			sync2_c_q <= 8'h00;
			sync3_c_q <= 8'h00;
			pin_c_q   <= 8'h00;
		end else begin
			sync1_b_q <= pin_b_in;
			sync2_b_q <= sync1_b_q;
			sync3_b_q <= sync2_b_q;
			pin_b_q   <= (pin_b_q & ~(sync2_b_q ^~ sync3_b_q)) | (sync3_b_q & (sync2_b_q ^~ sync3_b_q));
			sync1_c_q <= pin_c_in;
			sync2_c_q <= sync1_c_q;
			sync3_c_q <= sync2_c_q;
			pin_c_q   <= (pin_c_q & ~(sync2_c_q ^~ sync3_c_q)) | (sync3_c_q & (sync2_c_q ^~ sync3_c_q));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ss_active_q <= 1'b0;
		end else begin
			ss_active_q <= spi_slave & ~pin_b_q[0];
		end
	end

	// First port overrides
	always_comb begin
		port_b_ovr = '0;
		for (int i = 0; i < 8; i++) begin
			port_b_ovr[i].input_en_ovr_en  = mask0_q[i] & grp0_en;
			port_b_ovr[i].input_en_ovr_val = 1'b1;
		end
		// Data-out pin forced to input as master, pull-up still from port bit
		port_b_ovr[3].pullup_ovr_en  = spi_master;
		port_b_ovr[3].pullup_ovr_val = port_b_out[3] & ~global_pullup_disable;
		port_b_ovr[3].dir_ovr_en     = spi_master;
		port_b_ovr[3].value_ovr_en   = spi_slave;
		port_b_ovr[3].value_ovr_val  = periph_in.spi_slave_out;
		// Data-in and clock pins forced to input as slave
		for (int i = 1; i < 3; i++) begin
			port_b_ovr[i].pullup_ovr_en  = spi_slave;
			port_b_ovr[i].pullup_ovr_val = port_b_out[i] & ~global_pullup_disable;
			port_b_ovr[i].dir_ovr_en     = spi_slave;
			port_b_ovr[i].value_ovr_en   = spi_master;
		end
		port_b_ovr[2].value_ovr_val = periph_in.spi_master_out;
		port_b_ovr[1].value_ovr_val = periph_in.spi_sck_out;
		// Slave select carries no value override
		port_b_ovr[0].pullup_ovr_en  = spi_slave;
		port_b_ovr[0].pullup_ovr_val = port_b_out[0] & ~global_pullup_disable;
		port_b_ovr[0].dir_ovr_en     = spi_slave;
		// Timer 0 compare A takes precedence when both compares claim the pin
		port_b_ovr[7].value_ovr_en  = periph_in.tmr0_cmp_a_en | periph_in.tmr1_cmp_c_en;
		port_b_ovr[7].value_ovr_val = periph_in.tmr0_cmp_a_en ? periph_in.tmr0_cmp_a_out
			: periph_in.tmr1_cmp_c_out;
	end

	// Second port overrides
	always_comb begin
		port_c_ovr = '0;
		port_c_ovr[`PBCAF_C_CAPTURE_PIN].input_en_ovr_en  = periph_in.ext_irq4_enable;
		port_c_ovr[`PBCAF_C_CAPTURE_PIN].input_en_ovr_val = 1'b1;
		port_c_ovr[`PBCAF_C_CAPTURE_PIN].dir_ovr_en       = periph_in.clock_out_fuse_on;
		port_c_ovr[`PBCAF_C_CAPTURE_PIN].dir_ovr_val      = 1'b1;
		port_c_ovr[`PBCAF_C_CAPTURE_PIN].value_ovr_en     = periph_in.clock_out_fuse_on;
		port_c_ovr[`PBCAF_C_CAPTURE_PIN].value_ovr_val    = periph_in.osc_clock_out;
		// Compare outputs reach the pad only through the port's own direction bit
		port_c_ovr[`PBCAF_C_CMPA_PIN].value_ovr_en  = periph_in.tmr1_cmp_a_en;
		port_c_ovr[`PBCAF_C_CMPA_PIN].value_ovr_val = periph_in.tmr1_cmp_a_out;
		port_c_ovr[`PBCAF_C_CMPB_PIN].value_ovr_en  = periph_in.tmr1_cmp_b_en;
		port_c_ovr[`PBCAF_C_CMPB_PIN].value_ovr_val = periph_in.tmr1_cmp_b_out;
		port_c_ovr[`PBCAF_C_CMPA_PIN].input_en_ovr_en = mask1_q[0] & grp1_en;
		port_c_ovr[`PBCAF_C_CMPB_PIN].input_en_ovr_en = mask1_q[1] & grp1_en;
		port_c_ovr[`PBCAF_C_PC10_PIN].input_en_ovr_en = mask1_q[2] & grp1_en;
		port_c_ovr[`PBCAF_C_PC11_PIN].input_en_ovr_en = mask1_q[3] & grp1_en;
		port_c_ovr[`PBCAF_C_CMPA_PIN].input_en_ovr_val = 1'b1;
		port_c_ovr[`PBCAF_C_CMPB_PIN].input_en_ovr_val = 1'b1;
		port_c_ovr[`PBCAF_C_PC10_PIN].input_en_ovr_val = 1'b1;
		port_c_ovr[`PBCAF_C_PC11_PIN].input_en_ovr_val = 1'b1;
		// Debug wins over reset: an open-drain line that only ever pulls low
		if (!periph_in.debug_enable_fuse && periph_in.lock_bits_unprogrammed) begin
			port_c_ovr[`PBCAF_C_RESET_PIN].pullup_ovr_en    = 1'b1;
			port_c_ovr[`PBCAF_C_RESET_PIN].pullup_ovr_val   = 1'b1;
			port_c_ovr[`PBCAF_C_RESET_PIN].dir_ovr_en       = 1'b1;
			port_c_ovr[`PBCAF_C_RESET_PIN].dir_ovr_val      = periph_in.debug_drive_low;
			port_c_ovr[`PBCAF_C_RESET_PIN].value_ovr_en     = 1'b1;
			port_c_ovr[`PBCAF_C_RESET_PIN].input_en_ovr_en  = 1'b1;
			port_c_ovr[`PBCAF_C_RESET_PIN].input_en_ovr_val = 1'b1;
		end else if (periph_in.reset_pin_disable_fuse) begin
			port_c_ovr[`PBCAF_C_RESET_PIN].pullup_ovr_en    = 1'b1;
			port_c_ovr[`PBCAF_C_RESET_PIN].pullup_ovr_val   = 1'b1;
			port_c_ovr[`PBCAF_C_RESET_PIN].dir_ovr_en       = 1'b1;
			port_c_ovr[`PBCAF_C_RESET_PIN].input_en_ovr_en  = 1'b1;
		end
	end

	// Pad resolution, purely combinational so overrides act in the same cycle
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pad
			always_comb begin
				pad_b[g].pullup_en = port_b_ovr[g].pullup_ovr_en ? port_b_ovr[g].pullup_ovr_val
					: (~port_b_dir[g] & port_b_out[g] & ~global_pullup_disable);
				pad_b[g].drive_en  = port_b_ovr[g].dir_ovr_en ? port_b_ovr[g].dir_ovr_val
					: port_b_dir[g];
				pad_b[g].drive_val = port_b_ovr[g].value_ovr_en ? port_b_ovr[g].value_ovr_val
					: port_b_out[g];
				pad_b[g].input_en  = port_b_ovr[g].input_en_ovr_en ? port_b_ovr[g].input_en_ovr_val
					: ~periph_in.sleep_input_off;
				pad_c[g].pullup_en = port_c_ovr[g].pullup_ovr_en ? port_c_ovr[g].pullup_ovr_val
					: (~port_c_dir[g] & port_c_out[g] & ~global_pullup_disable);
				pad_c[g].drive_en  = port_c_ovr[g].dir_ovr_en ? port_c_ovr[g].dir_ovr_val
					: port_c_dir[g];
				pad_c[g].drive_val = port_c_ovr[g].value_ovr_en ? port_c_ovr[g].value_ovr_val
					: port_c_out[g];
				pad_c[g].input_en  = port_c_ovr[g].input_en_ovr_en ? port_c_ovr[g].input_en_ovr_val
					: ~periph_in.sleep_input_off;
			end
		end
	endgenerate

	// Peripheral inputs taken from raw pad levels
	always_comb begin
		periph_out.spi_master_in        = pin_b_in[3];
		periph_out.spi_slave_in         = pin_b_in[2];
		periph_out.spi_sck_in           = pin_b_in[1];
		periph_out.spi_slave_select     = spi_slave ? pin_b_in[0] : 1'b1;
		periph_out.prog_clock_in        = pin_b_in[1];
		periph_out.prog_data_in         = pin_b_in[2];
		periph_out.tmr1_count_in        = pin_b_in[4];
		periph_out.tmr1_capture_in      = pin_c_in[`PBCAF_C_CAPTURE_PIN];
		periph_out.ext_irq4_in          = pin_c_in[`PBCAF_C_CAPTURE_PIN];
		periph_out.pin_change_src[7:0]  = pin_b_in;
		periph_out.pin_change_src[8]    = pin_c_in[`PBCAF_C_CMPA_PIN];
		periph_out.pin_change_src[9]    = pin_c_in[`PBCAF_C_CMPB_PIN];
		periph_out.pin_change_src[10]   = pin_c_in[`PBCAF_C_PC10_PIN];
		periph_out.pin_change_src[11]   = pin_c_in[`PBCAF_C_PC11_PIN];
		// Reset role has its digital input off; the analog reset path sees the pad
		periph_out.ext_reset_n          = periph_in.reset_pin_disable_fuse
			? pin_c_in[`PBCAF_C_RESET_PIN] : 1'b1;
		periph_out.single_wire_debug_rx = pin_c_in[`PBCAF_C_RESET_PIN];
	end

endmodule

// [hdl/pbcaf_cfg.svh]
`ifndef PBCAF_CFG_SVH
`define PBCAF_CFG_SVH

// Register byte offsets
`define PBCAF_CTRL_OFS        8'h00
`define PBCAF_MASK0_OFS       8'h04
`define PBCAF_MASK1_OFS       8'h08
`define PBCAF_STATUS_OFS      8'h0C

// Control register fields
`define PBCAF_CTRL_GRP0_BIT   0
`define PBCAF_CTRL_GRP1_BIT   1
`define PBCAF_CTRL_PUD_BIT    4

// Status register fields
`define PBCAF_STAT_PINB_LSB   0
`define PBCAF_STAT_PINC_LSB   8
`define PBCAF_STAT_SSACT_BIT  16

// Reset values
`define PBCAF_CTRL_RST        8'h00
`define PBCAF_MASK0_RST       8'h00
`define PBCAF_MASK1_RST       4'h0

// Pin positions on the second port
`define PBCAF_C_CAPTURE_PIN   7
`define PBCAF_C_CMPA_PIN      6
`define PBCAF_C_CMPB_PIN      5
`define PBCAF_C_PC10_PIN      4
`define PBCAF_C_PC11_PIN      2
`define PBCAF_C_RESET_PIN     1

`endif

// [hdl/pbcaf_pkg.sv]
package pbcaf_pkg;

	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} pbcaf_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} pbcaf_apb_rsp_t;

	// Override set handed to one port cell
	typedef struct packed {
		logic pullup_ovr_en;
		logic pullup_ovr_val;
		logic dir_ovr_en;
		logic dir_ovr_val;
		logic value_ovr_en;
		logic value_ovr_val;
		logic input_en_ovr_en;
		logic input_en_ovr_val;
	} pbcaf_pin_ovr_t;

	// Resolved drive of one pad
	typedef struct packed {
		logic pullup_en;
		logic drive_en;
		logic drive_val;
		logic input_en;
	} pbcaf_pad_t;

	typedef struct packed {
		logic serial_if_enable;
		logic serial_master_select;
		logic spi_slave_out;
		logic spi_master_out;
		logic spi_sck_out;
		logic tmr0_cmp_a_en;
		logic tmr0_cmp_a_out;
		logic tmr1_cmp_c_en;
		logic tmr1_cmp_c_out;
		logic tmr1_cmp_a_en;
		logic tmr1_cmp_a_out;
		logic tmr1_cmp_b_en;
		logic tmr1_cmp_b_out;
		logic ext_irq4_enable;
		logic clock_out_fuse_on;
		logic osc_clock_out;
		logic reset_pin_disable_fuse;
		logic debug_enable_fuse;
		logic lock_bits_unprogrammed;
		logic debug_drive_low;
		logic sleep_input_off;
	} pbcaf_periph_in_t;

	typedef struct packed {
		logic        spi_master_in;
		logic        spi_slave_in;
		logic        spi_sck_in;
		logic        spi_slave_select;
		logic        prog_clock_in;
		logic        prog_data_in;
		logic        tmr1_count_in;
		logic        tmr1_capture_in;
		logic        ext_irq4_in;
		logic [11:0] pin_change_src;
		logic        ext_reset_n;
		logic        single_wire_debug_rx;
	} pbcaf_periph_out_t;

endpackage

// [testbench/pbcaf_chk.sv]
`timescale 1ns/1ps
module pbcaf_chk
	import pbcaf_pkg::*;
#(
	parameter int PORT_WIDTH = 8
) (
	input wire logic	pclk,
	input wire logic	presetn,
	input wire pbcaf_pkg::pbcaf_apb_req_t	apb_req,
	input wire pbcaf_pkg::pbcaf_apb_rsp_t	apb_rsp,
	input wire pbcaf_pkg::pbcaf_periph_in_t	periph_in,
	input wire pbcaf_pkg::pbcaf_periph_out_t	periph_out,
	input wire logic [PORT_WIDTH-1:0]	port_b_dir,
	input wire logic [PORT_WIDTH-1:0]	port_c_dir,
	input wire logic [PORT_WIDTH-1:0]	pin_c_in,
	input wire pbcaf_pkg::pbcaf_pin_ovr_t [PORT_WIDTH-1:0]	port_b_ovr,
	input wire pbcaf_pkg::pbcaf_pad_t [PORT_WIDTH-1:0]	pad_b,
	input wire pbcaf_pkg::pbcaf_pad_t [PORT_WIDTH-1:0]	pad_c
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic	slv;
	logic	mst;
	assign slv = periph_in.serial_if_enable & ~periph_in.serial_master_select;
	assign mst = periph_in.serial_if_enable & periph_in.serial_master_select;
	sequence s_setup;
		apb_req.psel && !apb_req.penable;
	endsequence
	sequence s_access;
		apb_req.psel && apb_req.penable && apb_rsp.pready;
	endsequence
	a_apb_no_wait: assert property (s_setup |=> s_access ##1 !apb_rsp.pready)
		else $error("access phase not answered in one cycle");
	a_mosi_forced_in: assert property (slv |-> port_b_ovr[2].dir_ovr_en && !pad_b[2].drive_en)
		else $error("data-in pin driven in slave mode");
	a_sck_forced_in: assert property (slv |-> port_b_ovr[1].dir_ovr_en && !pad_b[1].drive_en)
		else $error("clock pin driven in slave mode");
	a_ss_forced_in: assert property (slv |-> port_b_ovr[0].dir_ovr_en && !pad_b[0].drive_en)
		else $error("select pin driven in slave mode");
	a_miso_forced_in: assert property (mst |-> port_b_ovr[3].dir_ovr_en && !pad_b[3].drive_en)
		else $error("data-out pin driven in master mode");
	a_dir_same_cycle: assert property ($changed(port_b_dir[2]) && mst |->
		pad_b[2].drive_en == port_b_dir[2])
		else $error("direction change not seen in same cycle");
	a_cmp_a_pin: assert property (port_c_dir[6] && periph_in.tmr1_cmp_a_en |->
		pad_c[6].drive_en && pad_c[6].drive_val == periph_in.tmr1_cmp_a_out)
		else $error("compare A not on its pin");
	a_capture_route: assert property (!periph_in.sleep_input_off |->
		periph_out.tmr1_capture_in == pin_c_in[7] && periph_out.ext_irq4_in == pin_c_in[7])
		else $error("capture or irq4 input not routed");
	a_reset_role: assert property (periph_in.reset_pin_disable_fuse && periph_in.debug_enable_fuse
		|-> pad_c[1].pullup_en && !pad_c[1].drive_en && !pad_c[1].input_en)
		else $error("reset pin cell wrong");
	a_debug_line: assert property (!periph_in.debug_enable_fuse && periph_in.lock_bits_unprogrammed
		|-> pad_c[1].pullup_en && !pad_c[1].drive_val
		&& pad_c[1].drive_en == periph_in.debug_drive_low)
		else $error("debug line not open-drain");
endmodule

bind pbcaf_override pbcaf_chk #(.PORT_WIDTH(PORT_WIDTH)) pbcaf_chk_inst (.pclk, .presetn,
	.apb_req, .apb_rsp, .periph_in, .periph_out, .port_b_dir, .port_c_dir, .pin_c_in,
	.port_b_ovr, .pad_b, .pad_c);

// [testbench/pbcaf_pins.sv]
`timescale 1ns/1ps
module pbcaf_pins
	import pbcaf_pkg::*;
(
	input wire logic	pclk,
	input wire pbcaf_pkg::pbcaf_pad_t [7:0]	pad_b,
	input wire pbcaf_pkg::pbcaf_pad_t [7:0]	pad_c,
	input wire logic [15:0]	ext_en,
	input wire logic [15:0]	ext_val,
	output logic [7:0]	pin_b_in,
	output logic [7:0]	pin_c_in
);
	logic	float_q = 1'h0;
	logic [15:0]	lvl;
	pbcaf_pad_t [15:0]	pad;
	// An undriven pin without pull-up wanders instead of holding its last value
	always @(posedge pclk) float_q <= ~float_q;
	assign pad = {pad_c, pad_b};
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			lvl[i] = pad[i].pullup_en | float_q & ~pad[i].pullup_en;
			if (ext_en[i]) lvl[i] = ext_val[i];
			// Wired-AND: a board driver can only pull a driven line low
			if (pad[i].drive_en) lvl[i] = pad[i].drive_val & (~ext_en[i] | ext_val[i]);
		end
	end
	assign {pin_c_in, pin_b_in} = lvl;
endmodule

// [testbench/test_port_b_c_alt_function_override.sv]
`timescale 1ns/1ps
`include "pbcaf_cfg.svh"
module test_port_b_c_alt_function_override;
	import pbcaf_pkg::*;
	logic	pclk = 1'h0;
	logic	presetn = 1'h0;
	pbcaf_apb_req_t	rq = '0;
	pbcaf_apb_rsp_t	rs;
	pbcaf_periph_in_t	pi = '0;
	pbcaf_periph_out_t	po;
	logic [7:0]	bd = '0;
	logic [7:0]	bo = '0;
	logic [7:0]	cd = '0;
	logic [7:0]	co = '0;
	logic [7:0]	bin;
	logic [7:0]	cin;
	logic [15:0]	xe = '0;
	logic [15:0]	xv = '0;
	pbcaf_pin_ovr_t [7:0]	ob;
	pbcaf_pin_ovr_t [7:0]	oc;
	pbcaf_pad_t [7:0]	pb;
	pbcaf_pad_t [7:0]	pc;
	logic [31:0]	rdat;
	logic	rerr;
	int	fails = 0;
	int	comparisons = 0;
	pbcaf_override #(.PORT_WIDTH(8)) pbcaf_override_inst (.pclk(pclk), .presetn(presetn),
		.apb_req(rq), .apb_rsp(rs), .periph_in(pi), .periph_out(po), .port_b_dir(bd),
		.port_b_out(bo), .port_c_dir(cd), .port_c_out(co), .pin_b_in(bin), .pin_c_in(cin),
		.port_b_ovr(ob), .port_c_ovr(oc), .pad_b(pb), .pad_c(pc));
	pbcaf_pins pbcaf_pins_inst (.pclk(pclk), .pad_b(pb), .pad_c(pc), .ext_en(xe),
		.ext_val(xv), .pin_b_in(bin), .pin_c_in(cin));
	initial forever #5 pclk = ~pclk;
	task automatic wrap_up;
		if (fails == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		rq.psel <= 1'h1;
		rq.penable <= 1'h0;
		rq.pwrite <= w;
		rq.paddr <= a;
		rq.pwdata <= d;
		@(posedge pclk);
		rq.penable <= 1'h1;
		// Only the watchdog ends a wait for an answer that never comes
		do begin
			@(posedge pclk);
		end while (rs.pready !== 1'h1);
		rdat = rs.prdata;
		rerr = rs.pslverr;
		rq.psel <= 1'h0;
		rq.penable <= 1'h0;
	endtask
	task automatic t_regs;
		apb(1'h0, `PBCAF_CTRL_OFS, '0);
		chk(rdat, 32'h0);
		apb(1'h1, `PBCAF_CTRL_OFS, 32'hFFFFFFFF);
		apb(1'h0, `PBCAF_CTRL_OFS, '0);
		chk(rdat, 32'h13);
		apb(1'h0, 8'h10, '0);
		chk({rdat[30:0], rerr}, 32'h1);
		apb(1'h1, `PBCAF_CTRL_OFS, '0);
	endtask
	task automatic t_serial;
		logic [3:0] f;
		logic [7:0] v;
		for (int m = 0; m < 4; m++) begin
			@(posedge pclk);
			pi.serial_if_enable <= m[1];
			pi.serial_master_select <= m[0];
			bd <= 8'h0F;
			bo <= 8'h2F;
			f = {m == 3, m == 2, m == 2, m == 2};
			@(negedge pclk);
			for (int k = 0; k < 4; k++) begin
				chk(pb[k].drive_en, !f[k]);
				chk(pb[k].pullup_en, f[k]);
			end
			if (m != 3) chk(pb[3].drive_val, m != 2);
			if (m != 2) chk({pb[2].drive_val, pb[1].drive_val}, {2{m != 3}});
		end
		apb(1'h1, `PBCAF_CTRL_OFS, 32'h10);
		@(negedge pclk);
		chk({pb[5].pullup_en, pb[3].pullup_en}, 2'h0);
		apb(1'h1, `PBCAF_CTRL_OFS, 32'h0);
		@(negedge pclk);
		chk({pb[5].pullup_en, pb[3].pullup_en}, 2'h3);
		for (int i = 0; i < 2; i++) begin
			@(posedge pclk);
			v = i ? 8'hCA : 8'h35;
			bd <= 8'h00;
			xe <= 16'h00FF;
			xv <= {8'h00, v};
			@(negedge pclk);
			chk(po.pin_change_src[7:0], v);
			chk({po.spi_master_in, po.spi_slave_in, po.tmr1_count_in}, {v[3], v[2], v[4]});
			chk({po.prog_data_in, po.prog_clock_in}, v[2:1]);
		end
	endtask
	task automatic t_ss;
		@(posedge pclk);
		pi.serial_master_select <= 1'h0;
		for (int i = 0; i < 2; i++) begin
			xv[0] <= i[0];
			repeat (8) @(posedge pclk);
			apb(1'h0, `PBCAF_STATUS_OFS, '0);
			chk(rdat[16], !i[0]);
			chk(rdat[7:1], 7'h65);
			chk({po.spi_slave_select, po.spi_sck_in}, {i[0], 1'h1});
		end
	endtask
	task automatic t_change;
		logic [7:0] e;
		apb(1'h1, `PBCAF_MASK0_OFS, 32'hA5);
		apb(1'h1, `PBCAF_MASK1_OFS, 32'h5);
		apb(1'h1, `PBCAF_CTRL_OFS, 32'h3);
		pi.sleep_input_off <= 1'h1;
		xe <= 16'h7400;
		xv <= 16'h5000;
		@(negedge pclk);
		for (int k = 0; k < 8; k++) begin
			e = 8'hA5 >> k;
			chk({ob[k].input_en_ovr_en, pb[k].input_en, ob[k].input_en_ovr_val | !e[0]},
				{e[0], e[0], 1'h1});
		end
		chk({oc[6].input_en_ovr_en, oc[5].input_en_ovr_en, oc[4].input_en_ovr_en,
			oc[2].input_en_ovr_en}, 4'hA);
		chk(po.pin_change_src[11:8], 4'h5);
		apb(1'h1, `PBCAF_CTRL_OFS, 32'h0);
		pi.sleep_input_off <= 1'h0;
		@(negedge pclk);
		chk({ob[7].input_en_ovr_en, ob[0].input_en_ovr_en, oc[6].input_en_ovr_en}, 3'h0);
	endtask
	task automatic t_port_c;
		@(posedge pclk);
		pi.tmr1_cmp_a_en <= 1'h1;
		pi.tmr1_cmp_b_en <= 1'h1;
		pi.tmr0_cmp_a_en <= 1'h1;
		co <= 8'hFF;
		bo <= 8'hFF;
		bd <= 8'h80;
		xe <= 16'h8000;
		for (int i = 0; i < 2; i++) begin
			cd <= i ? 8'h20 : 8'h40;
			xv[15] <= i[0];
			@(negedge pclk);
			chk({pc[6].drive_en, pc[5].drive_en}, {!i[0], i[0]});
			chk({pc[6].drive_val, pc[5].drive_val}, 2'h0);
			chk({po.tmr1_capture_in, po.ext_irq4_in}, {2{i[0]}});
			chk({ob[7].value_ovr_en, pb[7].drive_val}, 2'h2);
			@(posedge pclk);
		end
		pi.tmr0_cmp_a_en <= 1'h0;
		pi.tmr1_cmp_c_en <= 1'h1;
		pi.clock_out_fuse_on <= 1'h1;
		xe <= 16'h0;
		@(negedge pclk);
		chk({ob[7].value_ovr_en, pb[7].drive_val}, 2'h2);
		chk({pc[7].drive_en, pc[7].drive_val, cin[7]}, 3'h4);
	endtask
	task automatic t_reset_pin;
		@(posedge pclk);
		pi.clock_out_fuse_on <= 1'h0;
		pi.reset_pin_disable_fuse <= 1'h1;
		pi.debug_enable_fuse <= 1'h1;
		xe <= 16'h0200;
		xv <= 16'h0;
		@(negedge pclk);
		chk({pc[1].pullup_en, pc[1].drive_en, pc[1].input_en, po.ext_reset_n}, 4'h8);
		@(posedge pclk);
		pi.debug_enable_fuse <= 1'h0;
		pi.lock_bits_unprogrammed <= 1'h1;
		xe <= 16'h0;
		for (int i = 0; i < 2; i++) begin
			pi.debug_drive_low <= !i[0];
			@(negedge pclk);
			chk({pc[1].pullup_en, pc[1].drive_en, cin[1], po.single_wire_debug_rx},
				i ? 4'hB : 4'hC);
			@(posedge pclk);
		end
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_serial();
		t_ss();
		t_change();
		t_port_c();
		t_reset_pin();
		wrap_up();
	end
	// Whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge pclk);
		fails++;
		wrap_up();
	end
endmodule
